/* inc/can_filter_defines.svh */
// constants shared by the acceptance filter ends
// Behaviour
// - software deactivates bank before reconfiguring it
// - scale field selects filter width per bank
// - low mode bit bytes 1-4, high 5-8
// - 16-bit: mode bits govern bytes 3-4, 7-8
// - 8-bit: mode bits govern bytes 2,4 / 6,8
// - 32-bit scale needs equal mode bits
// - standard frame skips extended identifier bits
// - mask for groups, list for singles
// - unused banks stay inactive
// - every filter numbered from zero
// - 32-bit: bytes 1-4 identifier, 5-8 mask/id
// - 16-bit: mask half one, list half two
// - mixed: 16-bit low, two 8-bit high
// - scale zero gives four 8-bit filters
// - mask one bits must match, zero ignored
// - list mode needs every bit equal
// - priority: width, then list, then number
`ifndef CAN_FILTER_DEFINES_SVH
`define CAN_FILTER_DEFINES_SVH
`define FLT_NUM_BANKS 6
`define FLT_IDX_W 6
// filter number counts per half
`define FLT_CNT_MASK16 3'h1
`define FLT_CNT_LIST16 3'h2
`define FLT_CNT_MASK8 3'h2
`define FLT_CNT_LIST8 3'h4
// priority ranks, lower wins; none means no hit
`define FLT_RANK_LIST32 3'h0
`define FLT_RANK_MASK32 3'h1
`define FLT_RANK_LIST16 3'h2
`define FLT_RANK_MASK16 3'h3
`define FLT_RANK_LIST8 3'h4
`define FLT_RANK_MASK8 3'h5
`define FLT_RANK_NONE 3'h7
// extended bits ignored for standard frames
`define FLT_CARE32_STD 32'hfff8_0001
`define FLT_CARE16_STD 16'hfff8
// configuration port selectors
`define FLT_SEL_CONFIG 4'h8
`define FLT_SEL_MODE 4'h9
// config byte fields
`define FLT_CFG_ACTIVE_BIT 0
`define FLT_CFG_SCALE_LSB 1
`define FLT_MODE_LOW_BIT 0
`define FLT_MODE_HIGH_BIT 1
// reset values
`define FLT_RST_BYTE 8'h00
`define FLT_RST_SCALE 2'h0
// apb register offsets
`define FLT_REG_CMD 12'h000
`define FLT_REG_IDREQ 12'h004
`define FLT_REG_RESULT 12'h008
// command register fields
`define FLT_CMD_SEL_LSB 0
`define FLT_CMD_BANK_LSB 4
`define FLT_CMD_DATA_LSB 8
// identifier request fields
`define FLT_IDREQ_IDE_BIT 29
`define FLT_IDREQ_RTR_BIT 30
// result register fields
`define FLT_RES_DONE_BIT 0
`define FLT_RES_HIT_BIT 1
`define FLT_RES_IDX_LSB 8
`endif

/* inc/can_filter_pkg.sv */
// types of the acceptance filter ends
package can_filter_pkg;
  typedef enum logic [1:0] {
    SCALE_8 = 2'h0,
    SCALE_16_8 = 2'h1,
    SCALE_16 = 2'h2,
    SCALE_32 = 2'h3
  } bank_scale_type;
endpackage

/* inc/filt_if.sv */
// link between filter controller and filter bank logic
`timescale 1ns/1ps
`include "can_filter_defines.svh"
interface filt_if;
  logic cfg_wr;
  logic [2:0] cfg_bank;
  logic [3:0] cfg_sel;
  logic [7:0] cfg_data;
  logic id_valid;
  logic [28:0] id_bits;
  logic id_ide;
  logic id_rtr;
  logic match_valid;
  logic match_hit;
  logic [`FLT_IDX_W-1:0] match_index;
  modport dev (
    input cfg_wr, cfg_bank, cfg_sel, cfg_data,
    input id_valid, id_bits, id_ide, id_rtr,
    output match_valid, match_hit, match_index
  );
  modport host (
    output cfg_wr, cfg_bank, cfg_sel, cfg_data,
    output id_valid, id_bits, id_ide, id_rtr,
    input match_valid, match_hit, match_index
  );
endinterface

/* logic/can_filter_bank.sv */
// six acceptance filter banks: configuration store and matcher
`timescale 1ns/1ps
`include "can_filter_defines.svh"
module can_filter_bank
  import can_filter_pkg::*;
#(
  parameter int NUM_BANKS = `FLT_NUM_BANKS
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // link to the controller
  filt_if.dev link,
  // bank activation state
  output logic [NUM_BANKS-1:0] bank_active_out
);

  logic [7:0] bank_filter_byte_ff [NUM_BANKS][8];
  logic [NUM_BANKS-1:0] bank_active_ff;
  logic [NUM_BANKS-1:0] low_half_list_sel_ff;
  logic [NUM_BANKS-1:0] high_half_list_sel_ff;
  bank_scale_type bank_scale_sel_ff [NUM_BANKS];
  logic match_valid_ff;
  logic match_hit_ff;
  logic [`FLT_IDX_W-1:0] match_index_ff;

  logic bank_ok;
  logic bank_idle;
  logic [31:0] in32;
  logic [31:0] care32;
  logic [15:0] care16;
  logic [2:0] best_rank;
  logic [`FLT_IDX_W-1:0] best_idx;
  logic [`FLT_IDX_W-1:0] num;
  logic [31:0] lo_w;
  logic [31:0] hi_w;
  logic [3:0] hits [2];
  logic [2:0] rank [2];
  logic [2:0] cnt [2];

  // a write to a missing bank is dropped
  assign bank_ok = ({29'h0000_0000, link.cfg_bank} < NUM_BANKS);
  assign bank_idle = bank_ok && !bank_active_ff[link.cfg_bank];

  // filter bytes change only while the bank is inactive
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      bank_filter_byte_ff <= '{default: '{default: `FLT_RST_BYTE}};
    end
    else if (link.cfg_wr && bank_idle && !link.cfg_sel[3])
    begin
      bank_filter_byte_ff[link.cfg_bank][link.cfg_sel[2:0]] <=
        link.cfg_data;
    end
  end

  // activation bit is always writable so software can switch off
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      bank_active_ff <= '0;
    end
    else if (link.cfg_wr && bank_ok && link.cfg_sel == `FLT_SEL_CONFIG)
    begin
      bank_active_ff[link.cfg_bank] <=
        link.cfg_data[`FLT_CFG_ACTIVE_BIT];
    end
  end

  // scale is frozen while the bank is active
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      bank_scale_sel_ff <= '{default: bank_scale_type'(`FLT_RST_SCALE)};
    end
    else if (link.cfg_wr && bank_idle && link.cfg_sel == `FLT_SEL_CONFIG)
    begin
      bank_scale_sel_ff[link.cfg_bank] <= bank_scale_type'(
        link.cfg_data[`FLT_CFG_SCALE_LSB +: 2]);
    end
  end

  // mode bits, one per half, frozen while active
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      low_half_list_sel_ff <= '0;
      high_half_list_sel_ff <= '0;
    end
    else if (link.cfg_wr && bank_idle && link.cfg_sel == `FLT_SEL_MODE)
    begin
      low_half_list_sel_ff[link.cfg_bank] <=
        link.cfg_data[`FLT_MODE_LOW_BIT];
      high_half_list_sel_ff[link.cfg_bank] <=
        link.cfg_data[`FLT_MODE_HIGH_BIT];
    end
  end

  // hits of one half: 16-bit id/m or 8-bit id/m/id/m layout
  function automatic logic [3:0] half_hits(
    input logic [31:0] w,
    input logic is8,
    input logic list,
    input logic [15:0] v16,
    input logic [15:0] c16,
    input logic [7:0] v8
  );
    logic [3:0] h;
    h = 4'h0;
    if (is8 && list)
    begin
      h[0] = (v8 == w[31:24]);
      h[1] = (v8 == w[23:16]);
      h[2] = (v8 == w[15:8]);
      h[3] = (v8 == w[7:0]);
    end
    else if (is8)
    begin
      h[0] = (((v8 ^ w[31:24]) & w[23:16]) == 8'h00);
      h[1] = (((v8 ^ w[15:8]) & w[7:0]) == 8'h00);
    end
    else if (list)
    begin
      h[0] = (((v16 ^ w[31:16]) & c16) == 16'h0000);
      h[1] = (((v16 ^ w[15:0]) & c16) == 16'h0000);
    end
    else
    begin
      h[0] = (((v16 ^ w[31:16]) & w[15:0] & c16) == 16'h0000);
    end
    return h;
  endfunction

  // incoming frame laid out as the 32-bit filter word
  assign in32 = {link.id_bits[28:18], link.id_rtr, link.id_ide,
                 link.id_bits[17:0], 1'b0};
  // standard frames leave the extended part uncompared
  assign care32 = link.id_ide ? 32'hffff_ffff : `FLT_CARE32_STD;
  assign care16 = link.id_ide ? 16'hffff : `FLT_CARE16_STD;

  // one pass over all banks; numbers count inactive banks too,
  // so software indices stay fixed when banks switch off
  always_comb
  begin
    best_rank = `FLT_RANK_NONE;
    best_idx = '0;
    num = '0;
    lo_w = 32'h0000_0000;
    hi_w = 32'h0000_0000;
    for (int h = 0; h < 2; h++)
    begin
      hits[h] = 4'h0;
      rank[h] = `FLT_RANK_NONE;
      cnt[h] = 3'h0;
    end
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      lo_w = {bank_filter_byte_ff[b][0], bank_filter_byte_ff[b][1],
              bank_filter_byte_ff[b][2], bank_filter_byte_ff[b][3]};
      hi_w = {bank_filter_byte_ff[b][4], bank_filter_byte_ff[b][5],
              bank_filter_byte_ff[b][6], bank_filter_byte_ff[b][7]};
      if (bank_scale_sel_ff[b] == SCALE_32)
      begin
        // low mode bit taken for the whole bank; mixed bits are misuse
        if (low_half_list_sel_ff[b])
        begin
          hits[0] = {2'b00, ((in32 ^ hi_w) & care32) == 32'h0,
                     ((in32 ^ lo_w) & care32) == 32'h0};
          rank[0] = `FLT_RANK_LIST32;
          cnt[0] = `FLT_CNT_LIST16;
        end
        else
        begin
          hits[0] = {3'b000,
                     ((in32 ^ lo_w) & hi_w & care32) == 32'h0};
          rank[0] = `FLT_RANK_MASK32;
          cnt[0] = `FLT_CNT_MASK16;
        end
        hits[1] = 4'h0;
        rank[1] = `FLT_RANK_NONE;
        cnt[1] = 3'h0;
      end
      else
      begin
        hits[0] = half_hits(lo_w, bank_scale_sel_ff[b] == SCALE_8,
          low_half_list_sel_ff[b], in32[31:16], care16, in32[31:24]);
        hits[1] = half_hits(hi_w, bank_scale_sel_ff[b] != SCALE_16,
          high_half_list_sel_ff[b], in32[31:16], care16, in32[31:24]);
        if (bank_scale_sel_ff[b] == SCALE_8)
        begin
          rank[0] = low_half_list_sel_ff[b] ? `FLT_RANK_LIST8 :
                                              `FLT_RANK_MASK8;
          cnt[0] = low_half_list_sel_ff[b] ? `FLT_CNT_LIST8 :
                                             `FLT_CNT_MASK8;
        end
        else
        begin
          rank[0] = low_half_list_sel_ff[b] ? `FLT_RANK_LIST16 :
                                              `FLT_RANK_MASK16;
          cnt[0] = low_half_list_sel_ff[b] ? `FLT_CNT_LIST16 :
                                             `FLT_CNT_MASK16;
        end
        if (bank_scale_sel_ff[b] == SCALE_16)
        begin
          rank[1] = high_half_list_sel_ff[b] ? `FLT_RANK_LIST16 :
                                               `FLT_RANK_MASK16;
          cnt[1] = high_half_list_sel_ff[b] ? `FLT_CNT_LIST16 :
                                              `FLT_CNT_MASK16;
        end
        else
        begin
          rank[1] = high_half_list_sel_ff[b] ? `FLT_RANK_LIST8 :
                                               `FLT_RANK_MASK8;
          cnt[1] = high_half_list_sel_ff[b] ? `FLT_CNT_LIST8 :
                                              `FLT_CNT_MASK8;
        end
      end
      // low half numbered first, then high half, then next bank
      for (int h = 0; h < 2; h++)
      begin
        for (int k = 0; k < 4; k++)
        begin
          // strict compare keeps the lowest number within a rank
          if (hits[h][k] && bank_active_ff[b] && rank[h] < best_rank)
          begin
            best_rank = rank[h];
            best_idx = num + `FLT_IDX_W'(k);
          end
        end
        num = num + `FLT_IDX_W'(cnt[h]);
      end
    end
  end

  // answer one cycle after the identifier is presented
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      match_valid_ff <= 1'b0;
      match_hit_ff <= 1'b0;
      match_index_ff <= '0;
    end
    else
    begin
      match_valid_ff <= link.id_valid;
      if (link.id_valid)
      begin
        match_hit_ff <= (best_rank != `FLT_RANK_NONE);
        match_index_ff <= best_idx;
      end
    end
  end

  assign link.match_valid = match_valid_ff;
  assign link.match_hit = match_hit_ff;
  assign link.match_index = match_index_ff;
  assign bank_active_out = bank_active_ff;

endmodule

/* logic/can_filter_ctrl.sv */
// apb-facing controller that drives the filter bank link
`timescale 1ns/1ps
`include "can_filter_defines.svh"
module can_filter_ctrl
  import can_filter_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // link to the filter banks
  filt_if.host link
);

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic cfg_wr_ff;
  logic [2:0] cfg_bank_ff;
  logic [3:0] cfg_sel_ff;
  logic [7:0] cfg_data_ff;
  logic id_valid_ff;
  logic [28:0] id_bits_ff;
  logic id_ide_ff;
  logic id_rtr_ff;
  logic done_ff;
  logic hit_ff;
  logic [`FLT_IDX_W-1:0] idx_ff;
  logic access;
  logic commit;
  logic mapped;
  logic [31:0] rd_val;

  // one wait state gives registered read data
  assign access = psel_in && penable_in && !pready_ff;
  assign commit = psel_in && penable_in && pready_ff && pwrite_in;
  assign mapped = (paddr_in == `FLT_REG_CMD) ||
                  (paddr_in == `FLT_REG_IDREQ) ||
                  (paddr_in == `FLT_REG_RESULT);

  // read mux; write-only command register reads zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (paddr_in == `FLT_REG_IDREQ)
    begin
      rd_val = {1'b0, id_rtr_ff, id_ide_ff, id_bits_ff};
    end
    else if (paddr_in == `FLT_REG_RESULT)
    begin
      rd_val[`FLT_RES_DONE_BIT] = done_ff;
      rd_val[`FLT_RES_HIT_BIT] = hit_ff;
      rd_val[`FLT_RES_IDX_LSB +: `FLT_IDX_W] = idx_ff;
    end
  end

  // bus handshake and read data
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= access;
      pslverr_ff <= access && !mapped;
      if (access)
      begin
        prdata_ff <= pwrite_in ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // configuration write pulse toward the banks
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cfg_wr_ff <= 1'b0;
      cfg_bank_ff <= 3'h0;
      cfg_sel_ff <= 4'h0;
      cfg_data_ff <= 8'h00;
    end
    else
    begin
      cfg_wr_ff <= commit && paddr_in == `FLT_REG_CMD;
      if (commit && paddr_in == `FLT_REG_CMD)
      begin
        cfg_sel_ff <= pwdata_in[`FLT_CMD_SEL_LSB +: 4];
        cfg_bank_ff <= pwdata_in[`FLT_CMD_BANK_LSB +: 3];
        cfg_data_ff <= pwdata_in[`FLT_CMD_DATA_LSB +: 8];
      end
    end
  end

  // identifier request pulse
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      id_valid_ff <= 1'b0;
      id_bits_ff <= 29'h0000_0000;
      id_ide_ff <= 1'b0;
      id_rtr_ff <= 1'b0;
    end
    else
    begin
      id_valid_ff <= commit && paddr_in == `FLT_REG_IDREQ;
      if (commit && paddr_in == `FLT_REG_IDREQ)
      begin
        id_bits_ff <= pwdata_in[28:0];
        id_ide_ff <= pwdata_in[`FLT_IDREQ_IDE_BIT];
        id_rtr_ff <= pwdata_in[`FLT_IDREQ_RTR_BIT];
      end
    end
  end

  // result capture; an answer beats a clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      done_ff <= 1'b0;
      hit_ff <= 1'b0;
      idx_ff <= '0;
    end
    else if (link.match_valid)
    begin
      done_ff <= 1'b1;
      hit_ff <= link.match_hit;
      idx_ff <= link.match_index;
    end
    else if (commit && paddr_in == `FLT_REG_IDREQ)
    begin
      done_ff <= 1'b0;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign link.cfg_wr = cfg_wr_ff;
  assign link.cfg_bank = cfg_bank_ff;
  assign link.cfg_sel = cfg_sel_ff;
  assign link.cfg_data = cfg_data_ff;
  assign link.id_valid = id_valid_ff;
  assign link.id_bits = id_bits_ff;
  assign link.id_ide = id_ide_ff;
  assign link.id_rtr = id_rtr_ff;

endmodule

/* dv/can_filter_asserts.sv */
// assertions on the link between filter controller and filter banks
`timescale 1ns/1ps
`include "can_filter_defines.svh"
module can_filter_asserts
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // link signals
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_bank,
  input wire logic [3:0] cfg_sel,
  input wire logic [7:0] cfg_data,
  input wire logic id_valid,
  input wire logic id_ide,
  input wire logic match_valid,
  input wire logic match_hit,
  input wire logic [`FLT_IDX_W-1:0] match_index,
  // bank state
  input wire logic [5:0] bank_active_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  // every request answered exactly one cycle later, never unasked
  a_match_after_req: assert property (id_valid |=> match_valid)
    else $error("match answer missing after request");
  a_match_needs_req: assert property (match_valid |-> $past(id_valid))
    else $error("match answer without request");
  // verdict must hold between answers, software reads it late
  a_result_held: assert property (!match_valid |->
    $stable(match_hit) && $stable(match_index))
    else $error("match result changed without answer");
  // activation bit is always writable, other writes leave it alone
  a_active_write: assert property (cfg_wr && cfg_sel == 4'h8 &&
    cfg_bank < 3'h6 |=> bank_active_out[$past(cfg_bank)] == $past(cfg_data[0]))
    else $error("activation write not taken");
  a_active_still: assert property (!(cfg_wr && cfg_sel == 4'h8)
    |=> $stable(bank_active_out))
    else $error("activation changed without config write");
  // no hit while all banks are inactive; numbering stays within six banks of eight
  a_idle_no_hit: assert property (match_valid &&
    $past(bank_active_out) == 6'h00 |-> !match_hit)
    else $error("hit reported with all banks inactive");
  a_index_range: assert property (match_valid && match_hit |->
    match_index < 6'd48)
    else $error("match index beyond last filter");
  // apb wait state spaces link pulses at least three cycles apart
  a_cfg_spacing: assert property (cfg_wr |=> !cfg_wr [*2])
    else $error("config pulses too close");
  a_req_spacing: assert property (id_valid |=> !id_valid [*2])
    else $error("match requests too close");
  c_hit: cover property (match_valid && match_hit);
  c_miss: cover property (match_valid && !match_hit);
  c_std_hit: cover property (id_valid && !id_ide ##1 match_hit);
  c_mode_wr: cover property (cfg_wr && cfg_sel == 4'h9);
endmodule

/* dv/tb_top.sv */
// self-checking bench for the filter controller and banks
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in;
  logic sys_rst_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [5:0] bank_active_out;
  logic [31:0] rd;
  logic er;
  int n_fail;
  int n_tests;
  int best_r;
  int best_n;
  // reference copy of every bank's configuration
  bit [5:0] act;
  bit [1:0] scl [6];
  bit [1:0] mde [6];
  bit [7:0] byt [6][8];
  filt_if link ();
  can_filter_ctrl can_filter_ctrl_inst (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .link(link));
  can_filter_bank #(.NUM_BANKS(6)) can_filter_bank_inst (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(link),
    .bank_active_out(bank_active_out));
  can_filter_asserts can_filter_asserts_inst (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .cfg_wr(link.cfg_wr), .cfg_bank(link.cfg_bank),
    .cfg_sel(link.cfg_sel), .cfg_data(link.cfg_data),
    .id_valid(link.id_valid), .id_ide(link.id_ide),
    .match_valid(link.match_valid), .match_hit(link.match_hit),
    .match_index(link.match_index), .bank_active_out(bank_active_out));
  // clock at 50 MHz
  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys_in);
      k++;
    end
    while (pready_out !== 1'b1 && k < 40);
    chk("pready", 32'h1, {31'h0, pready_out});
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // config write; reference ignores all but activation while active
  task automatic cfg(input int b, s, input logic [7:0] d);
    apb(1'b1, 12'h000, {16'h0000, d, 1'b0, 3'(b), 4'(s)});
    chk("cfg_err", 32'h0, {31'h0, er});
    if (b < 6 && !act[b] && s < 8) byt[b][s] = d;
    if (b < 6 && !act[b] && s == 9) mde[b] = d[1:0];
    if (b < 6 && !act[b] && s == 8) scl[b] = d[2:1];
    if (b < 6 && s == 8) act[b] = d[0];
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("bank_active", {26'h0, act}, {26'h0, bank_active_out});
  endtask
  task automatic prog_bank(input int b, s, m, a, input logic [7:0] keep);
    cfg(b, 8, 8'h00);
    for (int k = 0; k < 8; k++) cfg(b, k, 8'($urandom) & keep);
    cfg(b, 9, 8'(m));
    cfg(b, 8, 8'((s << 1) | a));
    cfg(b, 3, 8'($urandom));
  endtask
  function automatic bit fit(logic [31:0] v, a, m);
    return ((v ^ a) & m) == 32'h0;
  endfunction
  // keeps the best rank; ascending numbers make ties go to the lowest
  function automatic void take(int r, n, bit h, on);
    if (h && on && r < best_r)
    begin
      best_r = r;
      best_n = n;
    end
  endfunction
  task automatic half(input bit w16, lst, on, input logic [31:0] hw, w,
                      input logic [15:0] c, inout int n);
    if (w16 && lst)
    begin
      take(2, n, fit(w[31:16], hw[31:16], c), on);
      take(2, n + 1, fit(w[31:16], hw[15:0], c), on);
    end
    if (w16 && !lst)
      take(3, n, fit(w[31:16], hw[31:16], hw[15:0] & c), on);
    for (int k = 0; k < 4; k++)
      if (!w16 && lst)
        take(4, n + k, fit(w[31:24], hw[31-8*k -: 8], 8'hff), on);
    if (!w16 && !lst)
    begin
      take(5, n, fit(w[31:24], hw[31:24], hw[23:16]), on);
      take(5, n + 1, fit(w[31:24], hw[15:8], hw[7:0]), on);
    end
    n += w16 ? (lst ? 2 : 1) : (lst ? 4 : 2);
  endtask
  task automatic model(input logic [31:0] w);
    logic [31:0] c32, lo, hi;
    int n;
    n = 0;
    best_r = 7;
    c32 = w[19] ? 32'hffff_ffff : 32'hfff8_0001;
    for (int b = 0; b < 6; b++)
    begin
      lo = {byt[b][0], byt[b][1], byt[b][2], byt[b][3]};
      hi = {byt[b][4], byt[b][5], byt[b][6], byt[b][7]};
      if (scl[b] == 2'h3 && mde[b][0])
      begin
        take(0, n, fit(w, lo, c32), act[b]);
        take(0, n + 1, fit(w, hi, c32), act[b]);
        n += 2;
      end
      else if (scl[b] == 2'h3)
      begin
        take(1, n, fit(w, lo, hi & c32), act[b]);
        n += 1;
      end
      else
      begin
        half(scl[b] != 2'h0, mde[b][0], act[b], lo, w,
             w[19] ? 16'hffff : 16'hfff8, n);
        half(scl[b] == 2'h2, mde[b][1], act[b], hi, w,
             w[19] ? 16'hffff : 16'hfff8, n);
      end
    end
  endtask
  // one identifier through the matcher, result polled over apb
  task automatic probe(input logic [31:0] wi);
    logic [31:0] w;
    logic [31:0] q;
    int k;
    w = {wi[31:1], 1'b0};
    q = {1'b0, w[20], w[19], w[31:21], w[18:1]};
    model(w);
    apb(1'b1, 12'h004, q);
    k = 0;
    do
    begin
      apb(1'b0, 12'h008, 32'h0);
      k++;
    end
    while (rd[0] !== 1'b1 && k < 8);
    chk("done", 32'h1, {31'h0, rd[0]});
    chk("hit", 32'(best_r != 7), {31'h0, rd[1]});
    if (best_r != 7) chk("index", best_n, {26'h0, rd[13:8]});
    // request register reads back what was written
    apb(1'b0, 12'h004, 32'h0);
    chk("idreq_rd", q, rd);
  endtask
  // identifiers taken from each byte rotation of a bank's halves
  task automatic probe_bank(input int b);
    logic [31:0] w;
    for (int h = 0; h < 2; h++)
      for (int r = 0; r < 4; r++)
      begin
        w = {byt[b][4*h+r], byt[b][4*h+(r+1)%4], byt[b][4*h+(r+2)%4],
             byt[b][4*h+(r+3)%4]};
        probe(w);
      end
    probe({w[31:20], 1'b0, 19'($urandom)});
    probe($urandom);
  endtask
  // timeout well beyond the expected run length
  initial
  begin
    #(20 * 60000);
    n_fail++;
    finish_test();
  end
  initial
  begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= '0;
    sys_rst_in <= 1'b1;
    void'($urandom(32'h6f73));
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("active_rst", 32'h0, {26'h0, bank_active_out});
    apb(1'b0, 12'h008, 32'h0);
    chk("result_rst", 32'h0, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk("unmapped_wr", 32'h1, {31'h0, er});
    apb(1'b0, 12'h000, 32'h0);
    chk("cmd_rd", 32'h0, rd);
    cfg(6, 8, 8'h01);
    cfg(0, 10, 8'hff);
    // the numbering example: mixed scales, two banks inactive
    prog_bank(0, 3, 3, 1, 8'hff);
    prog_bank(1, 3, 0, 1, 8'hff);
    prog_bank(2, 2, 3, 1, 8'hff);
    prog_bank(3, 0, 1, 0, 8'hff);
    prog_bank(4, 2, 0, 0, 8'hff);
    prog_bank(5, 1, 0, 1, 8'h00);
    for (int b = 0; b < 6; b++) probe_bank(b);
    // every scale and mode on bank 0, 32-bit scale only with equal mode bits
    cfg(5, 8, 8'h00);
    for (int s = 0; s < 4; s++)
      for (int m = 0; m < 4; m++)
      begin
        prog_bank(0, s, (s == 3) ? (m[0] ? 3 : 0) : m, 1, 8'hff);
        probe_bank(0);
      end
    // all banks off: no identifier may hit any more
    for (int b = 0; b < 6; b++) cfg(b, 8, 8'h00);
    repeat (4) probe($urandom);
    finish_test();
  end
endmodule
